// ==== olp_pkg.sv ====
package olp_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          PTR_LSB          = 4;
  localparam logic [7:0]  CTRL_CUR_OFFSET  = 8'h24;
  localparam logic [7:0]  BULK_HEAD_OFFSET = 8'h28;
  localparam logic [31:0] CTRL_CUR_RESET   = 32'h0000_0000;
  localparam logic [31:0] BULK_HEAD_RESET  = 32'h0000_0000;
  localparam int          CLF_BIT          = 1;
  localparam int          CLE_BIT          = 4;
  localparam logic [31:0] PTR_MASK         = 32'hffff_fff0;
  localparam logic [31:0] END_OF_LIST      = 32'h0000_0000;

  typedef enum logic [1:0] {
    OLP_IDLE,
    OLP_WALK,
    OLP_DONE
  } olp_walk_t;

  function automatic logic [31:0] olp_align(input logic [31:0] v);
    olp_align = v & PTR_MASK;
  endfunction : olp_align
endpackage : olp_pkg

// ==== olp_ptr_reg.sv ====
`timescale 1ns/1ps
// One 16-byte aligned pointer register with priority load then write.
module olp_ptr_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        wr,
  input  wire logic [31:0] wr_val,
  output logic [31:0]      value
);
  import olp_pkg::*;

  typedef struct packed {
    logic [31:0] ptr;
  } olp_ptr_state_t;

  olp_ptr_state_t st_q;
  olp_ptr_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.ptr = olp_align(load_val);
    end else if (wr) begin
      st_d.ptr = olp_align(wr_val);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{ptr: RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.ptr;
endmodule : olp_ptr_reg

// ==== olp_read_mux.sv ====
`timescale 1ns/1ps
module olp_read_mux (
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] ctrl_cur,
  input  wire logic [31:0] bulk_head,
  output logic [31:0]      rdata
);
  import olp_pkg::*;

  always_comb begin
    case (addr)
      CTRL_CUR_OFFSET:  rdata = olp_align(ctrl_cur);
      BULK_HEAD_OFFSET: rdata = olp_align(bulk_head);
      default:          rdata = 32'h0000_0000;
    endcase
  end
endmodule : olp_read_mux

// ==== olp_list_ptr_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Control current pointer sits at 24h, 32 bits, software-writable only while control processing is disabled.
// - After serving a descriptor, control current pointer advances to next.
// - Each frame resumes control processing where the previous frame stopped.
// - At control list end, the filled flag at status bit 1 is examined.
// - Flag set at end: load control head into current, then clear flag.
// - Flag clear at end: leave pointer and flag alone, do nothing more.
// - Control current pointer resets to zero; zero means list end.
// - Bulk head pointer sits at 28h, 32 bits, read and write.
// - Every bulk traversal starts at the bulk head pointer.
// - At initialization bulk head is loaded from host communication area.
module olp_list_ptr_regs (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic [olp_pkg::ADDR_W-1:0] ADDR,
  input  wire logic                 WR,
  input  wire logic                 RD,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 CTRL_ENABLE,
  input  wire logic                 CTRL_FILLED,
  input  wire logic [31:0]          CTRL_HEAD,
  input  wire logic                 DESC_DONE,
  input  wire logic [31:0]          NEXT_DESC,
  input  wire logic                 FRAME_START,
  input  wire logic                 INIT_LOAD,
  input  wire logic [31:0]          INIT_BULK_HEAD,
  input  wire logic                 BULK_START,
  output logic [31:0]               RDATA,
  output logic                      RVALID,
  output logic                      CLEAR_FILLED,
  output logic [31:0]               CTRL_CUR_PTR,
  output logic                      CTRL_AT_END,
  output logic                      CTRL_ACTIVE,
  output logic [31:0]               BULK_WALK_PTR,
  output logic                      BULK_WALK_VALID
);
  import olp_pkg::*;

  typedef struct packed {
    olp_walk_t   walk;
    logic [31:0] rdata;
    logic        rvalid;
    logic        clr_filled;
    logic        at_end;
    logic        active;
    logic [31:0] bulk_walk;
    logic        bulk_valid;
  } olp_state_t;

  olp_state_t  s_q;
  olp_state_t  s_d;
  logic [31:0] ctrl_cur;
  logic [31:0] bulk_head;
  logic [31:0] mux_rdata;
  logic        cur_load;
  logic [31:0] cur_load_val;
  logic        cur_wr;
  logic        bulk_wr;

  // Control current pointer write only honoured while control processing is disabled
  assign cur_wr  = WR && (ADDR == CTRL_CUR_OFFSET) && !CTRL_ENABLE;
  assign bulk_wr = WR && (ADDR == BULK_HEAD_OFFSET);

  always_comb begin
    cur_load     = 1'b0;
    cur_load_val = ctrl_cur;
    if (CTRL_ENABLE && DESC_DONE && ctrl_cur != END_OF_LIST) begin
      cur_load     = 1'b1;
      cur_load_val = NEXT_DESC;
    end else if (CTRL_ENABLE && ctrl_cur == END_OF_LIST && s_q.walk == OLP_WALK
                 && CTRL_FILLED && !s_q.clr_filled) begin
      cur_load     = 1'b1;
      cur_load_val = CTRL_HEAD;
    end
  end

  olp_ptr_reg #(
    .RESET_VAL (CTRL_CUR_RESET)
  ) u_ctrl_cur (
    .clk      (CLK),
    .nrst     (NRST),
    .load     (cur_load),
    .load_val (cur_load_val),
    .wr       (cur_wr),
    .wr_val   (WDATA),
    .value    (ctrl_cur)
  );

  olp_ptr_reg #(
    .RESET_VAL (BULK_HEAD_RESET)
  ) u_bulk_head (
    .clk      (CLK),
    .nrst     (NRST),
    .load     (INIT_LOAD),
    .load_val (INIT_BULK_HEAD),
    .wr       (bulk_wr),
    .wr_val   (WDATA),
    .value    (bulk_head)
  );

  olp_read_mux u_mux (
    .addr      (ADDR),
    .ctrl_cur  (ctrl_cur),
    .bulk_head (bulk_head),
    .rdata     (mux_rdata)
  );

  always_comb begin
    s_d            = s_q;
    s_d.rvalid     = RD;
    s_d.clr_filled = 1'b0;
    s_d.bulk_valid = 1'b0;
    if (RD) begin
      s_d.rdata = mux_rdata;
    end
    // Walk state survives frame boundaries so the pointer is never rewound
    case (s_q.walk)
      OLP_IDLE: begin
        if (CTRL_ENABLE && FRAME_START) begin
          s_d.walk = OLP_WALK;
        end
      end
      OLP_WALK: begin
        if (!CTRL_ENABLE) begin
          s_d.walk = OLP_IDLE;
        end else if (ctrl_cur == END_OF_LIST) begin
          if (CTRL_FILLED) begin
            s_d.clr_filled = 1'b1;
            s_d.walk       = OLP_WALK;
          end else begin
            s_d.walk = OLP_DONE;
          end
        end
      end
      OLP_DONE: begin
        // Nothing more this frame; next frame checks the flag again
        if (!CTRL_ENABLE) begin
          s_d.walk = OLP_IDLE;
        end else if (FRAME_START) begin
          s_d.walk = OLP_WALK;
        end
      end
      default: s_d.walk = OLP_IDLE;
    endcase
    s_d.at_end = (cur_load ? olp_align(cur_load_val) :
                  cur_wr ? olp_align(WDATA) : ctrl_cur) == END_OF_LIST;
    s_d.active = (s_d.walk == OLP_WALK);
    if (BULK_START) begin
      s_d.bulk_walk  = bulk_head;
      s_d.bulk_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '{walk: OLP_IDLE, rdata: 32'h0000_0000, rvalid: 1'b0,
               clr_filled: 1'b0, at_end: 1'b1, active: 1'b0, bulk_walk: 32'h0000_0000,
               bulk_valid: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Pointer output is the register itself, already a flop
  assign CTRL_CUR_PTR    = ctrl_cur;
  assign RDATA           = s_q.rdata;
  assign RVALID          = s_q.rvalid;
  assign CLEAR_FILLED    = s_q.clr_filled;
  assign CTRL_AT_END     = s_q.at_end;
  assign CTRL_ACTIVE     = s_q.active;
  assign BULK_WALK_PTR   = s_q.bulk_walk;
  assign BULK_WALK_VALID = s_q.bulk_valid;
endmodule : olp_list_ptr_regs

// ==== olp_list_ptr_regs_props.sv ====
`timescale 1ns/1ps
module olp_list_ptr_regs_props (
  input wire logic                         CLK,
  input wire logic                         NRST,
  input wire logic [olp_pkg::ADDR_W-1:0]   ADDR,
  input wire logic                         WR,
  input wire logic                         RD,
  input wire logic                         CTRL_ENABLE,
  input wire logic                         CTRL_FILLED,
  input wire logic                         DESC_DONE,
  input wire logic [31:0]                  NEXT_DESC,
  input wire logic                         BULK_START,
  input wire logic [31:0]                  RDATA,
  input wire logic                         RVALID,
  input wire logic                         CLEAR_FILLED,
  input wire logic [31:0]                  CTRL_CUR_PTR,
  input wire logic                         CTRL_AT_END,
  input wire logic [31:0]                  BULK_WALK_PTR,
  input wire logic                         BULK_WALK_VALID
);
  import olp_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_read_answers: assert property (RD |=> RVALID) else $error("no read answer");
  a_ctrl_readback: assert property (RVALID && $past(ADDR) == 8'h24 |->
    RDATA == $past(CTRL_CUR_PTR)) else $error("control pointer read wrong");
  a_unmapped_zero: assert property (RVALID && !($past(ADDR) inside {8'h24, 8'h28})
    |-> RDATA == 32'h0) else $error("unmapped read not zero");
  a_low_bits_zero: assert property (CTRL_CUR_PTR[3:0] == 4'h0
    && BULK_WALK_PTR[3:0] == 4'h0) else $error("low pointer bits set");
  a_desc_advance: assert property (CTRL_ENABLE && DESC_DONE && CTRL_CUR_PTR != 32'h0 |=>
    CTRL_CUR_PTR == ($past(NEXT_DESC) & PTR_MASK)) else $error("pointer did not advance");
  a_end_flag: assert property (CTRL_AT_END == (CTRL_CUR_PTR == 32'h0))
    else $error("end flag wrong");
  a_clear_needs_flag: assert property (CLEAR_FILLED |-> $past(CTRL_FILLED))
    else $error("clear without filled flag");
  a_bulk_start: assert property (BULK_START |=> BULK_WALK_VALID)
    else $error("bulk walk not started");
  a_hold_no_cause: assert property (!CTRL_FILLED && !DESC_DONE && !WR
    |=> $stable(CTRL_CUR_PTR)) else $error("pointer moved without cause");
endmodule : olp_list_ptr_regs_props

bind olp_list_ptr_regs olp_list_ptr_regs_props u_props (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
  .WR(WR), .RD(RD), .CTRL_ENABLE(CTRL_ENABLE), .CTRL_FILLED(CTRL_FILLED),
  .DESC_DONE(DESC_DONE), .NEXT_DESC(NEXT_DESC),
  .BULK_START(BULK_START), .RDATA(RDATA), .RVALID(RVALID), .CLEAR_FILLED(CLEAR_FILLED),
  .CTRL_CUR_PTR(CTRL_CUR_PTR), .CTRL_AT_END(CTRL_AT_END), .BULK_WALK_PTR(BULK_WALK_PTR),
  .BULK_WALK_VALID(BULK_WALK_VALID));

// ==== olp_host_model.sv ====
`timescale 1ns/1ps
// Status flag as driver software sees it; set by software, cleared by the block
module olp_host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic set_filled,
  input  wire logic clear_filled,
  output logic      filled
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) filled <= 1'b0;
    // New work queued by software must not be lost to a clear in the same cycle
    else if (set_filled) filled <= 1'b1;
    else if (clear_filled) filled <= 1'b0;
  end
endmodule : olp_host_model

// ==== olp_list_ptr_regs_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module olp_list_ptr_regs_tb_top;
  import olp_pkg::*;
  logic CLK = 0, NRST = 0, WR = 0, RD = 0, CTRL_ENABLE = 0, DESC_DONE = 0, FRAME_START = 0;
  logic INIT_LOAD = 0, BULK_START = 0, set_filled = 0, CTRL_FILLED, RVALID, CLEAR_FILLED;
  logic CTRL_AT_END, CTRL_ACTIVE, BULK_WALK_VALID;
  logic [ADDR_W-1:0] ADDR = 0;
  logic [31:0] WDATA = 0, CTRL_HEAD = 0, NEXT_DESC = 0, INIT_BULK_HEAD = 0;
  logic [31:0] RDATA, CTRL_CUR_PTR, BULK_WALK_PTR, v, e;
  logic [31:0] exp_q[$];
  int error_cnt = 0, cmp_count = 0, seed = 95058;
  olp_list_ptr_regs u_olp_list_ptr_regs (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR(WR),
    .RD(RD), .WDATA(WDATA), .CTRL_ENABLE(CTRL_ENABLE), .CTRL_FILLED(CTRL_FILLED),
    .CTRL_HEAD(CTRL_HEAD), .DESC_DONE(DESC_DONE), .NEXT_DESC(NEXT_DESC),
    .FRAME_START(FRAME_START), .INIT_LOAD(INIT_LOAD), .INIT_BULK_HEAD(INIT_BULK_HEAD),
    .BULK_START(BULK_START), .RDATA(RDATA), .RVALID(RVALID), .CLEAR_FILLED(CLEAR_FILLED),
    .CTRL_CUR_PTR(CTRL_CUR_PTR), .CTRL_AT_END(CTRL_AT_END), .CTRL_ACTIVE(CTRL_ACTIVE),
    .BULK_WALK_PTR(BULK_WALK_PTR), .BULK_WALK_VALID(BULK_WALK_VALID));
  olp_host_model u_olp_host_model (.clk(CLK), .nrst(NRST), .set_filled(set_filled),
    .clear_filled(CLEAR_FILLED), .filled(CTRL_FILLED));
  always #25 CLK = ~CLK;
  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    ADDR = a;
    WR = w;
    RD = !w;
    WDATA = d;
    @(negedge CLK);
    WR = 0;
    RD = 0;
    @(negedge CLK);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge CLK);
    s = 0;
    @(negedge CLK);
  endtask : pulse
  // Compare at the falling edge so registered outputs have settled
  always @(negedge CLK) begin
    if (RVALID === 1'b1 || BULK_WALK_VALID === 1'b1) begin
      e = exp_q.pop_front();
      if (RVALID === 1'b1) `CHK("rdata", e, RDATA)
      else `CHK("bulk_walk_ptr", e, BULK_WALK_PTR)
    end
  end
  initial begin
    repeat (5) @(negedge CLK);
    NRST = 1;
    @(negedge CLK);
    `CHK("at_end", 1'b1, CTRL_AT_END)
    `CHK("active", 1'b0, CTRL_ACTIVE)
    rd(CTRL_CUR_OFFSET, CTRL_CUR_RESET);
    rd(BULK_HEAD_OFFSET, BULK_HEAD_RESET);
    rd(8'h2c, 32'h0);
    $display("test reset done");
    repeat (4) begin
      v = $random(seed) & PTR_MASK;
      bus(BULK_HEAD_OFFSET, 1'b1, v);
      rd(BULK_HEAD_OFFSET, v);
      exp_q.push_back(v);
      pulse(BULK_START);
    end
    v = $random(seed);
    bus(CTRL_CUR_OFFSET, 1'b1, v);
    rd(CTRL_CUR_OFFSET, v & PTR_MASK);
    INIT_BULK_HEAD = $random(seed) & PTR_MASK;
    pulse(INIT_LOAD);
    rd(BULK_HEAD_OFFSET, INIT_BULK_HEAD);
    $display("test registers done");
    CTRL_ENABLE = 1;
    pulse(FRAME_START);
    `CHK("active", 1'b1, CTRL_ACTIVE)
    // A write while enabled must be dropped
    bus(CTRL_CUR_OFFSET, 1'b1, 32'h1230);
    rd(CTRL_CUR_OFFSET, v & PTR_MASK);
    NEXT_DESC = 32'h5670;
    pulse(DESC_DONE);
    rd(CTRL_CUR_OFFSET, 32'h5670);
    NEXT_DESC = END_OF_LIST;
    pulse(DESC_DONE);
    repeat (3) @(negedge CLK);
    rd(CTRL_CUR_OFFSET, END_OF_LIST);
    `CHK("active", 1'b0, CTRL_ACTIVE)
    `CHK("at_end", 1'b1, CTRL_AT_END)
    CTRL_HEAD = 32'h9ab0;
    pulse(set_filled);
    pulse(FRAME_START);
    `CHK("clear_filled", 1'b1, CLEAR_FILLED)
    rd(CTRL_CUR_OFFSET, 32'h9ab0);
    `CHK("filled", 1'b0, CTRL_FILLED)
    `CHK("cur_ptr", 32'h9ab0, CTRL_CUR_PTR)
    `CHK("active", 1'b1, CTRL_ACTIVE)
    `CHK("at_end", 1'b0, CTRL_AT_END)
    CTRL_ENABLE = 0;
    @(negedge CLK);
    `CHK("active", 1'b0, CTRL_ACTIVE)
    $display("test control list done");
    report_and_stop();
  end
  initial begin
    #(2000 * 50);
    error_cnt++;
    report_and_stop();
  end
endmodule : olp_list_ptr_regs_tb_top
